/* hw/smc_pkg.sv */
// Package for the stop-mode and clock control block: offsets, fields, resets, timing.
package smc_pkg;

    // Register byte addresses (printed offsets are not word aligned, so index times four).
    localparam logic [7:0]  IDX_SYSTEM_CONTROL_ONE = 8'h38;     // Index of control register one.
    localparam logic [7:0]  IDX_SYSTEM_CONTROL_TWO = 8'h39;     // Index of control register two.
    localparam logic [7:0]  IDX_KEY_WAKEUP_CONTROL = 8'h3a;     // Index of key wakeup enables.
    localparam logic [7:0]  IDX_MODE_STATUS        = 8'h3b;     // Index of mode status word.
    localparam logic [11:0] ADDR_CTRL_ONE = {2'h0, IDX_SYSTEM_CONTROL_ONE, 2'h0};
    localparam logic [11:0] ADDR_CTRL_TWO = {2'h0, IDX_SYSTEM_CONTROL_TWO, 2'h0};
    localparam logic [11:0] ADDR_KEY_CTRL = {2'h0, IDX_KEY_WAKEUP_CONTROL, 2'h0};
    localparam logic [11:0] ADDR_STATUS   = {2'h0, IDX_MODE_STATUS, 2'h0};

    // Field positions in control register one.
    localparam int B1_STOP = 7;                                 // Stop start.
    localparam int B1_RELEASE_METHOD = 6;                                 // Release method.
    localparam int B1_RETURN_MODE_SELECT = 5;                                 // Return mode select.
    localparam int B1_OUTEN = 4;                                // Port output kept in stop.
    localparam int B1_WUT_HI = 3;                               // Warmup select high bit.
    localparam int B1_WUT_LO = 2;                               // Warmup select low bit.

    // Field positions in control register two.
    localparam int B2_XEN = 7;                                  // Fast oscillator enable.
    localparam int B2_XTEN = 6;                                 // Slow oscillator enable.
    localparam int B2_SYSCK = 5;                                // Main clock select.
    localparam int B2_IDLE = 4;                                 // CPU halt.
    localparam int B2_TGH = 2;                                  // Timing generator halt.

    // Reset values.
    localparam logic [7:0] RST_CTRL_ONE = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO = 8'h80;
    localparam logic [3:0] RST_KEY_CTRL = 4'h0;
    localparam logic [7:0] UNDEF_FILL   = 8'h00;                // Undefined bits read this value.

    // Warm-up lengths in oscillator periods, fast then slow, by select code.
    localparam logic [19:0] WU_FAST_00 = 20'h30000;             // 3 x 2^16.
    localparam logic [19:0] WU_FAST_01 = 20'h10000;             // 2^16.
    localparam logic [19:0] WU_FAST_10 = 20'h0c000;             // 3 x 2^14.
    localparam logic [19:0] WU_FAST_11 = 20'h04000;             // 2^14.
    localparam logic [19:0] WU_SLOW_00 = 20'h06000;             // 3 x 2^13.
    localparam logic [19:0] WU_SLOW_01 = 20'h02000;             // 2^13.
    localparam logic [19:0] WU_SLOW_10 = 20'h000c0;             // 3 x 2^6.
    localparam logic [19:0] WU_SLOW_11 = 20'h00040;             // 2^6.

    // Top-level operating states.
    typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WARM} smc_state_t;

    // Oscillator and halt controls toward the clock tree, carried together.
    typedef struct packed {
        logic fast_osc_en;                                      // Fast oscillator running.
        logic slow_osc_en;                                      // Slow oscillator running.
        logic use_slow_clk;                                     // Main clock is the slow one.
        logic cpu_halt;                                         // CPU and watchdog stopped.
        logic periph_halt;                                      // Peripherals unclocked.
        logic all_halt;                                         // Stop or warm-up, all halted.
    } smc_clk_ctl_t;

endpackage : smc_pkg

/* hw/smc_ctrl.sv */
// Stop-mode sequencer, oscillator control and system control registers on APB.
`timescale 1ns/1ps

// How it works
// R01: Register two holds both oscillator enables.
// R02: Clock select writes choice, reads clock used.
// R03: CPU halt bit stops CPU and watchdog.
// R04: Generator halt bit stops peripheral clocks.
// R05: Reset when running oscillator is disabled.
// R06: Bits three, one, zero read undefined.
// R07: Software never sets both halts together.
// R08: Halt bits self-clear on wake.
// R09: Software stops peripherals before generator halt.
// R10: Stop-start bit enters stop mode.
// R11: Stop keeps state, oscillators off.
// R12: Stop clears prescaler and generator divider.
// R13: Program counter held two ahead.
// R14: Level mode wakes on pin or keys.
// R15: Level mode start with wake skips stop.
// R16: Warm-up never returns to stop.
// R17: Edge-to-level switch waits for rising edge.
// R18: Edge mode wakes on rising pin only.
// R19: Restart oscillators per return mode.
// R20: Selectable warm-up delay then resume.
// R21: Reset pin low ends stop immediately.
// R22: Software masks interrupts around stop.
// R23: Warm-up codes pick documented period counts.
// R24: Return mode picks fast or slow.
// R25: Warm-up counter clocked by restarting oscillator.
module smc_ctrl
    import smc_pkg::*;
#(
    parameter int DUAL_CLOCK = 1                                // Slow oscillator is fitted.
)(
    // APB slave.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins, asynchronous to pclk.
    input  wire logic        stop_pin_n,                        // Stop pin, high releases.
    input  wire logic [3:0]  key_wakeup_input,                  // Key inputs, low is asserted.
    input  wire logic        reset_pin_n,                       // External reset pin.
    // Oscillator ticks: one-cycle enables from the clock generator.
    input  wire logic        fast_osc_tick,
    input  wire logic        slow_osc_tick,
    // Wake events for the halt modes from the interrupt controller.
    input  wire logic        cpu_halt_wake,
    input  wire logic        periph_halt_wake,
    // Core side.
    input  wire logic [15:0] stop_insn_pc,                      // Address of the stop instruction.
    output smc_clk_ctl_t     clk_ctl,
    output logic             clear_dividers,                    // Prescaler and divider cleared.
    output logic [15:0]      held_pc,
    output logic             port_hold,                         // Port outputs kept in stop.
    output logic             sys_reset_req                      // Internal reset request.
);

    localparam logic [15:0] PC_STEP  = 16'h0002;                // Bytes of the stop instruction.
    localparam logic [19:0] CNT_ONE  = 20'h00001;

    // Register state.
    logic [7:0]  ctrl_one_ff;                                   // Control one, stop bit excluded.
    logic        xen_ff;
    logic        xten_ff;
    logic        sel_slow_ff;                                   // Requested main clock.
    logic        use_slow_ff;                                   // Clock actually in use.
    logic        idle_ff;
    logic        tgh_ff;
    logic [3:0]  key_ctrl_ff;
    logic        reset_req_ff;
    smc_state_t  state_ff;
    logic [19:0] warm_cnt_ff;
    logic [19:0] warm_goal_ff;
    logic        warm_slow_ff;                                  // Warm-up counts slow ticks.
    logic        level_armed_ff;                                // Level mode has taken effect.
    logic [15:0] held_pc_ff;
    logic        clr_div_ff;

    // Pin synchronisers: first stage feeds only the second.
    logic [1:0]  stop_sync_ff;
    logic [3:0]  key_s1_ff;
    logic [3:0]  key_s2_ff;
    logic [1:0]  rst_sync_ff;
    logic        stop_prev_ff;                                  // Delayed synced pin for edges.

    // Decoded bus strokes and pin events.
    logic        wr_en;
    logic        rd_en;
    logic        stop_high;
    logic        stop_rise;
    logic        key_wake;
    logic        level_wake;
    logic        pin_reset;

    // The slave always answers in the access cycle; unmapped reads give zero, no error.
    // Read data is loaded in the setup cycle, so it already stands at the access edge.
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;

    // Synchronise every pin through two flip-flops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Stop pin stages start high so a high pin gives no false edge after reset.
            stop_sync_ff <= 2'h3;
            key_s1_ff    <= 4'hf;
            key_s2_ff    <= 4'hf;
            rst_sync_ff  <= 2'h3;
            stop_prev_ff <= 1'b1;
        end
        else
        begin
            stop_sync_ff <= {stop_sync_ff[0], stop_pin_n};
            key_s1_ff    <= key_wakeup_input;
            key_s2_ff    <= key_s1_ff;
            rst_sync_ff  <= {rst_sync_ff[0], reset_pin_n};
            stop_prev_ff <= stop_sync_ff[1];
        end
    end

    assign stop_high  = stop_sync_ff[1];
    assign stop_rise  = stop_sync_ff[1] & ~stop_prev_ff;
    assign key_wake   = |(~key_s2_ff & key_ctrl_ff);
    assign level_wake = stop_high | key_wake;                   // [R14]
    assign pin_reset  = ~rst_sync_ff[1];

    // Warm-up length from the select code and the oscillator being waited on.
    function automatic logic [19:0] warm_len(input logic [1:0] code, input logic slow);
        logic [19:0] len;
        len = WU_FAST_00;
        case ({slow, code})                                     // [R23]
            3'h0: len = WU_FAST_00;
            3'h1: len = WU_FAST_01;
            3'h2: len = WU_FAST_10;
            3'h3: len = WU_FAST_11;
            3'h4: len = WU_SLOW_00;
            3'h5: len = WU_SLOW_01;
            3'h6: len = WU_SLOW_10;
            default: len = WU_SLOW_11;
        endcase
        return len;
    endfunction : warm_len

    // Control register one and the key wakeup enables.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_one_ff <= RST_CTRL_ONE;
            key_ctrl_ff <= RST_KEY_CTRL;
        end
        else if (wr_en && paddr == ADDR_CTRL_ONE && state_ff == ST_RUN)
        begin
            // The stop bit is an action, not stored.
            ctrl_one_ff <= {1'b0, pwdata[6:2], 2'h0};
        end
        else if (wr_en && paddr == ADDR_KEY_CTRL)
        begin
            key_ctrl_ff <= pwdata[3:0];
        end
    end

    // Level mode is armed by a rising pin edge after a switch from edge mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level_armed_ff <= 1'b0;
        end
        else if (!ctrl_one_ff[B1_RELEASE_METHOD])
        begin
            // Edge mode disarms; the next switch must wait again.
            level_armed_ff <= 1'b0;
        end
        else if (stop_rise)
        begin
            level_armed_ff <= 1'b1;                             // [R17]
        end
    end

    // Operating state machine: run, stop, warm-up.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff     <= ST_RUN;
            warm_cnt_ff  <= 20'h0;
            warm_goal_ff <= 20'h0;
            warm_slow_ff <= 1'b0;
            held_pc_ff   <= 16'h0;
            clr_div_ff   <= 1'b0;
        end
        else if (pin_reset)
        begin
            // Reset pin ends stop at once with no warm-up wait.
            state_ff   <= ST_RUN;                               // [R21]
            clr_div_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                ST_RUN:
                begin
                    clr_div_ff <= 1'b0;
                    if (wr_en && paddr == ADDR_CTRL_ONE && pwdata[B1_STOP])  // [R10]
                    begin
                        held_pc_ff   <= stop_insn_pc + PC_STEP;  // [R13]
                        clr_div_ff   <= 1'b1;                   // [R12]
                        warm_slow_ff <= pwdata[B1_RETURN_MODE_SELECT] & (DUAL_CLOCK != 0);
                        warm_goal_ff <= warm_len(pwdata[B1_WUT_HI:B1_WUT_LO],
                                                 pwdata[B1_RETURN_MODE_SELECT] & (DUAL_CLOCK != 0));
                        warm_cnt_ff  <= 20'h0;
                        // Armed level mode with wake present skips stop.
                        if (pwdata[B1_RELEASE_METHOD] && level_armed_ff && level_wake)
                            state_ff <= ST_WARM;                // [R15]
                        else
                            state_ff <= ST_STOP;                // [R11] [R18]
                    end
                end
                ST_STOP:
                begin
                    clr_div_ff  <= 1'b1;                        // [R12]
                    warm_cnt_ff <= 20'h0;
                    if (ctrl_one_ff[B1_RELEASE_METHOD] && level_armed_ff && level_wake)
                        state_ff <= ST_WARM;                    // [R14]
                    else if (stop_rise)
                        state_ff <= ST_WARM;                    // [R18] [R17]
                end
                ST_WARM:
                begin
                    // No path back to stop: pin level is ignored here.
                    clr_div_ff <= 1'b1;                         // [R16]
                    if ((warm_slow_ff ? slow_osc_tick : fast_osc_tick))  // [R25]
                        warm_cnt_ff <= warm_cnt_ff + CNT_ONE;
                    if (warm_cnt_ff >= warm_goal_ff)
                        state_ff <= ST_RUN;                     // [R20]
                end
                default:
                begin
                    state_ff <= ST_RUN;
                end
            endcase
        end
    end

    // Oscillator enables and clock select of control register two.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xen_ff      <= RST_CTRL_TWO[B2_XEN];
            xten_ff     <= RST_CTRL_TWO[B2_XTEN];
            sel_slow_ff <= RST_CTRL_TWO[B2_SYSCK];
            use_slow_ff <= RST_CTRL_TWO[B2_SYSCK];
        end
        else if (pin_reset || reset_req_ff)
        begin
            // Any reset returns to fast single-clock run.
            xen_ff      <= 1'b1;                                // [R24]
            xten_ff     <= 1'b0;
            sel_slow_ff <= 1'b0;
            use_slow_ff <= 1'b0;
        end
        else if (state_ff == ST_WARM && warm_cnt_ff == 20'h0)
        begin
            // Restart per return mode: slow only, or fast, keeping slow on if dual and it was enabled before.
            xen_ff      <= ~warm_slow_ff;                       // [R19]
            xten_ff     <= warm_slow_ff | (xten_ff & (DUAL_CLOCK != 0));
            sel_slow_ff <= warm_slow_ff;                        // [R24]
            use_slow_ff <= warm_slow_ff;
        end
        else if (wr_en && paddr == ADDR_CTRL_TWO && state_ff == ST_RUN)
        begin
            xen_ff      <= pwdata[B2_XEN];                      // [R01]
            xten_ff     <= pwdata[B2_XTEN] & (DUAL_CLOCK != 0);
            sel_slow_ff <= pwdata[B2_SYSCK];
        end
        else if (sel_slow_ff != use_slow_ff)
        begin
            // Switch only once the target oscillator ticks, so the monitor lags.
            if (sel_slow_ff ? (xten_ff && slow_osc_tick) : (xen_ff && fast_osc_tick))
                use_slow_ff <= sel_slow_ff;                     // [R02]
        end
    end

    // Halt bits: set by software, self-cleared on wake; a same-cycle set wins over the wake.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_ff <= RST_CTRL_TWO[B2_IDLE];
            tgh_ff  <= RST_CTRL_TWO[B2_TGH];
        end
        else if (pin_reset || reset_req_ff)
        begin
            idle_ff <= 1'b0;
            tgh_ff  <= 1'b0;
        end
        else
        begin
            if (wr_en && paddr == ADDR_CTRL_TWO && pwdata[B2_IDLE])
                idle_ff <= 1'b1;                                // [R03]
            else if (idle_ff && cpu_halt_wake)
                idle_ff <= 1'b0;                                // [R08]
            if (wr_en && paddr == ADDR_CTRL_TWO && pwdata[B2_TGH])
                tgh_ff <= 1'b1;                                 // [R04]
            else if (tgh_ff && periph_halt_wake)
                tgh_ff <= 1'b0;                                 // [R08]
        end
    end

    // Reset when the oscillator feeding the main clock, or both, are off.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reset_req_ff <= 1'b0;
        else
            reset_req_ff <= state_ff == ST_RUN &&
                            ((!xen_ff && !xten_ff) || (!xen_ff && !use_slow_ff) ||
                             (!xten_ff && use_slow_ff));        // [R05]
    end

    // Read data register; undefined bits return the fill value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (rd_en && paddr == ADDR_CTRL_ONE)
            prdata <= {24'h0, 1'b0, ctrl_one_ff[6:2], UNDEF_FILL[1:0]};
        else if (rd_en && paddr == ADDR_CTRL_TWO)
            prdata <= {24'h0, xen_ff, xten_ff, use_slow_ff, idle_ff,
                       UNDEF_FILL[3], tgh_ff, UNDEF_FILL[1:0]};  // [R06]
        else if (rd_en && paddr == ADDR_KEY_CTRL)
            prdata <= {28'h0, key_ctrl_ff};
        else if (rd_en && paddr == ADDR_STATUS)
            prdata <= {28'h0, level_armed_ff, stop_high, state_ff};
        else if (rd_en)
            prdata <= 32'h0;
    end

    // Outputs toward the core and clock tree.
    always_comb
    begin
        clk_ctl.fast_osc_en  = xen_ff & (state_ff != ST_STOP);  // [R11]
        clk_ctl.slow_osc_en  = xten_ff & (state_ff != ST_STOP);
        clk_ctl.use_slow_clk = use_slow_ff;
        clk_ctl.cpu_halt     = idle_ff;
        clk_ctl.periph_halt  = tgh_ff;
        clk_ctl.all_halt     = state_ff != ST_RUN;              // [R20]
    end
    assign clear_dividers = clr_div_ff;
    assign held_pc        = held_pc_ff;
    assign port_hold      = ctrl_one_ff[B1_OUTEN];
    assign sys_reset_req  = reset_req_ff | pin_reset;

    // Checks.
    stop_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_RUN && !pin_reset && wr_en && paddr == ADDR_CTRL_ONE && pwdata[B1_STOP])
        |=> state_ff != ST_RUN) else $error("stop write ignored");  // [R10]
    pc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_STOP |=> $stable(held_pc))
        else $error("pc moved in stop");                        // [R13]
    osc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_STOP |-> !clk_ctl.fast_osc_en && !clk_ctl.slow_osc_en)
        else $error("oscillator on in stop");                   // [R11]
    warm_stay_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_WARM |=> state_ff != ST_STOP)
        else $error("warm-up fell back to stop");               // [R16]
    pin_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        pin_reset |=> state_ff == ST_RUN)
        else $error("reset pin did not end stop");              // [R21]
    div_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_STOP |-> clear_dividers)
        else $error("dividers not cleared in stop");            // [R12]
    osc_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_RUN && !xen_ff && !xten_ff) |=> sys_reset_req)
        else $error("no reset with both oscillators off");      // [R05]
    edge_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ST_STOP && !ctrl_one_ff[B1_RELEASE_METHOD] && !stop_rise && !pin_reset)
        |=> state_ff == ST_STOP) else $error("edge mode left stop without edge");  // [R18]

endmodule : smc_ctrl

/* tb/smc_osc_model.sv */
// Oscillator model: gives ticks only while the block keeps an oscillator enabled.
`timescale 1ns/1ps
module smc_osc_model
    import smc_pkg::*;
(
    // Clock, reset and oscillator controls.
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire smc_clk_ctl_t clk_ctl,
    // Ticks back to the block.
    output logic              fast_osc_tick,
    output logic              slow_osc_tick
);
    logic [1:0] slow_div_ff;                                    // Slow runs at a quarter rate.

    // A stopped oscillator gives no tick; a restarted one counts from zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slow_div_ff   <= 2'h0;
            fast_osc_tick <= 1'b0;
            slow_osc_tick <= 1'b0;
        end
        else
        begin
            fast_osc_tick <= clk_ctl.fast_osc_en;
            slow_div_ff   <= clk_ctl.slow_osc_en ? slow_div_ff + 2'h1 : 2'h0;
            slow_osc_tick <= clk_ctl.slow_osc_en && (slow_div_ff == 2'h3);
        end
    end
endmodule : smc_osc_model

/* tb/testbench.sv */
// Self-checking bench for the stop-mode and clock control block.
`timescale 1ns/1ps
module testbench;
    import smc_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic         stop_pin_n, reset_pin_n, cpu_wake, per_wake, f_tick, s_tick;
    logic         clr_div, port_hold, rst_req;
    logic [3:0]   keys;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [15:0]  held_pc;
    smc_clk_ctl_t ctl;
    int           error_cnt, tests_run, cnt;

    smc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_pin_n(stop_pin_n), .key_wakeup_input(keys),
        .reset_pin_n(reset_pin_n), .fast_osc_tick(f_tick), .slow_osc_tick(s_tick),
        .cpu_halt_wake(cpu_wake), .periph_halt_wake(per_wake), .stop_insn_pc(16'h1234),
        .clk_ctl(ctl), .clear_dividers(clr_div), .held_pc(held_pc),
        .port_hold(port_hold), .sys_reset_req(rst_req));
    smc_osc_model osc (.pclk(pclk), .presetn(presetn), .clk_ctl(ctl),
        .fast_osc_tick(f_tick), .slow_osc_tick(s_tick));

    // Clock of 8 ns.
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Verdict and end of run.
    task close_out;
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; read data is taken at the edge where pready is seen high.
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        rd = prdata;
        if (n == 20)
        begin
            error_cnt++;
            close_out();
        end
    endtask : apb

    // Waits, bounded, until the all-halt flag reaches a level; cnt holds the cycles.
    task halt_wait(input logic lvl);
        for (cnt = 0; cnt < 3000; cnt++)
        begin
            @(posedge pclk);
            if (ctl.all_halt === lvl)
                return;
        end
        error_cnt++;
        close_out();
    endtask : halt_wait

    task do_reset;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    // Gives the stop pin a clean rising edge.
    task pin_edge;
        stop_pin_n <= 1'b0;
        repeat (6) @(posedge pclk);
        stop_pin_n <= 1'b1;
    endtask : pin_edge

    // Reset value, loose bits, unmapped place, clock select monitor.
    task t_regs;
        apb(0, ADDR_CTRL_TWO, 8'h0);
        chk(rd, 32'h80);
        apb(0, 12'h100, 8'h0);
        chk(rd, 32'h0);
        apb(1, ADDR_CTRL_TWO, 8'heb);
        repeat (8) @(posedge pclk);
        apb(0, ADDR_CTRL_TWO, 8'h0);
        chk(rd, 32'he0);
        apb(1, ADDR_CTRL_TWO, 8'h60);
        @(negedge pclk);
        chk({ctl.fast_osc_en, ctl.slow_osc_en, ctl.use_slow_clk}, 3'b011);
    endtask : t_regs

    // Each halt bit acts, then clears itself on its wake event.
    task t_halts;
        apb(1, ADDR_CTRL_TWO, 8'h70);
        @(negedge pclk);
        chk({ctl.cpu_halt, ctl.periph_halt}, 2'b10);
        @(posedge pclk);
        cpu_wake <= 1'b1;
        @(posedge pclk);
        cpu_wake <= 1'b0;
        apb(0, ADDR_CTRL_TWO, 8'h0);
        chk(rd, 32'h60);
        apb(1, ADDR_CTRL_TWO, 8'h64);
        @(negedge pclk);
        chk({ctl.cpu_halt, ctl.periph_halt}, 2'b01);
        @(posedge pclk);
        per_wake <= 1'b1;
        @(posedge pclk);
        per_wake <= 1'b0;
        apb(0, ADDR_CTRL_TWO, 8'h0);
        chk(rd, 32'h60);
    endtask : t_halts

    // Edge release into slow mode, shortest slow warm-up of 64 slow periods.
    task t_edge;
        stop_pin_n <= 1'b1;
        apb(1, ADDR_CTRL_ONE, 8'hac);
        repeat (10) @(posedge pclk);
        chk({ctl.fast_osc_en, ctl.slow_osc_en, ctl.all_halt, clr_div}, 4'h3);
        chk(held_pc, 16'h1236);
        pin_edge();
        halt_wait(1'b0);
        chk(cnt >= 256 && cnt < 330, 1);
        chk({ctl.fast_osc_en, ctl.slow_osc_en}, 2'b01);
        apb(0, ADDR_CTRL_ONE, 8'h0);
        chk(rd, 32'h2c);
    endtask : t_edge

    // Level mode: needs a rising edge first, then skips stop, never falls back.
    task t_level;
        apb(1, ADDR_CTRL_ONE, 8'h6c);
        apb(1, ADDR_CTRL_ONE, 8'hec);
        repeat (4) @(posedge pclk);
        apb(0, ADDR_STATUS, 8'h0);
        chk(rd[1:0], 32'h1);
        pin_edge();
        halt_wait(1'b0);
        apb(1, ADDR_CTRL_ONE, 8'hec);
        apb(0, ADDR_STATUS, 8'h0);
        chk(rd[1:0], 32'h2);
        stop_pin_n <= 1'b0;
        halt_wait(1'b0);
        repeat (4) @(posedge pclk);
        apb(0, ADDR_STATUS, 8'h0);
        chk(rd[1:0], 32'h0);
        // Pin low, key zero enabled: stop holds until the key goes low.
        apb(1, ADDR_KEY_CTRL, 8'h1);
        apb(1, ADDR_CTRL_ONE, 8'hec);
        repeat (6) @(posedge pclk);
        chk(ctl.all_halt, 1);
        keys <= 4'he;
        halt_wait(1'b0);
        chk(cnt >= 256 && cnt < 330, 1);
        keys <= 4'hf;
    endtask : t_level

    // Reset pin in stop, then a disabled running oscillator.
    task t_resets;
        apb(1, ADDR_CTRL_ONE, 8'hac);
        repeat (4) @(posedge pclk);
        reset_pin_n <= 1'b0;
        repeat (5) @(posedge pclk);
        chk({rst_req, ctl.use_slow_clk}, 2'b10);
        reset_pin_n <= 1'b1;
        do_reset();
        repeat (4) @(posedge pclk);
        apb(1, ADDR_CTRL_TWO, 8'h40);
        @(posedge pclk);
        @(negedge pclk);
        chk(rst_req, 1);
    endtask : t_resets

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, cpu_wake, per_wake} = '0;
        {presetn, stop_pin_n, reset_pin_n} = 3'b011;
        keys = 4'hf;
        error_cnt = 0;
        tests_run = 0;
        do_reset();
        t_regs();
        t_halts();
        t_edge();
        t_level();
        t_resets();
        close_out();
    end
endmodule : testbench
